// file: qrvl_switch_ctrl.sv
// Overview of operation
// - 0-50 mV triangle at 250 Hz added
// - jitter polarity flips every switching cycle
// - demag input below 55 mV marks valley
// - valley starts pulse or advances valley count
// - target valley one to six from feedback
// - valley held within 600 mV hysteresis band
// - fixed falling and rising valley thresholds
// - timeout after demag counts as valley
// - steady valley timeout is 6 us
// - soft-start stretches timeout to 100 us
// - consecutive timeouts count toward target valley
// - max frequency clamp off, pin-set or 140 kHz
// - limit pin sets clamp, above 3 V disables
// - sixth valley under 0.8 V enters foldback
// - dead-time zero at 0.8 V, 36 us at 0.4 V
// - forced cycle keeps frequency above 25 kHz once a valley is counted
// - no dead-time before foldback engaged
// - foldback lowers peak setpoint from 0.4 V toward 0
// - foldback exits above 0.75 V
// - 1 ms lockout after every foldback change
// - skip or fifth-valley level exits at once
`timescale 1ns/100ps
`default_nettype none
module qrvl_switch_ctrl #(
    parameter int FB_W         = qrvl_pkg::FB_W,
    parameter int LOCKOUT_CYC  = qrvl_pkg::LOCKOUT_CYC,
    parameter int CLAMP_CYC    = qrvl_pkg::FREQ_LIMIT_PIN_CYC
) (
    input  wire logic            ref_clk,
    input  wire logic            sys_rst,
    input  wire logic            demag_below_thresh,
    input  wire logic            cs_trip,
    input  wire logic [FB_W-1:0] feedback_level,
    input  wire logic            feedback_below_skip,
    input  wire logic            soft_start,
    input  wire logic            freq_limit_enable,
    input  wire logic            freq_limit_pin_high,
    input  wire logic [15:0]     freq_limit_cyc,
    output logic                 gate_pulse,
    output logic                 jitter_negative,
    output logic [5:0]           jitter_mv,
    output logic [2:0]           valley_hold,
    output logic                 foldback_mode,
    output logic                 rapid_foldback,
    output logic [11:0]          peak_floor_mv,
    output logic [11:0]          peak_limit_mv
);
    localparam logic [15:0] STEADY_T  = 16'(qrvl_pkg::STEADY_TOUT_CYC);
    localparam logic [15:0] STARTUP_T = 16'(qrvl_pkg::STARTUP_TOUT_CYC);
    localparam logic [15:0] FMIN_T    = 16'(qrvl_pkg::FMIN_CYC);
    localparam logic [15:0] DEAD_T    = 16'(qrvl_pkg::MAX_DEAD_CYC);
    localparam logic [FB_W-1:0] ENTRY = FB_W'(qrvl_pkg::FB_ENTRY_MV);
    localparam logic [FB_W-1:0] EXIT  = FB_W'(qrvl_pkg::FB_EXIT_MV);
    localparam logic [FB_W-1:0] FLOOR = FB_W'(qrvl_pkg::FB_FLOOR_MV);

    qrvl_sync_if demag_if ();
    qrvl_sync_if cs_if ();
    assign demag_if.raw = demag_below_thresh;
    assign cs_if.raw    = cs_trip;

    qrvl_sync u_demag_sync (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .s       (demag_if)
    );
    qrvl_sync u_cs_sync (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .s       (cs_if)
    );

    qrvl_pkg::qrvl_state_t state;
    logic [15:0] period_cnt;
    logic [15:0] tout_cnt;
    logic [15:0] dead_cnt;
    logic [15:0] dead_target;
    logic [2:0]  valley_cnt;
    logic [31:0] lock_cnt;
    logic [15:0] jit_div;
    logic        jit_up;
    logic [15:0] clamp_cyc;
    logic        clamp_ok;
    logic        valley_evt;
    logic        tout_evt;
    logic [15:0] tout_len;
    logic [FB_W-1:0] fb_span;
    logic [FB_W-1:0] fifth_rise;

    // comparator flags arrive through synchronisers
    assign tout_len   = soft_start ? STARTUP_T : STEADY_T;
    assign tout_evt   = (state == qrvl_pkg::QRVL_HUNT) && (tout_cnt >= tout_len);
    assign valley_evt = demag_if.fall || tout_evt;
    // fifth-valley level is where the sixth hands back to the fifth
    assign fifth_rise = FB_W'(qrvl_pkg::RISE_MV[5]);

    // clamp: pin high disables, else pin resistor or fixed 140 kHz
    always_comb begin
        clamp_cyc = 16'(CLAMP_CYC);
        if (freq_limit_cyc != 16'h0000) begin
            clamp_cyc = freq_limit_cyc;
        end
        clamp_ok = !freq_limit_enable || freq_limit_pin_high || (period_cnt >= clamp_cyc);
    end

    // dead-time linear in feedback between 0.8 V and 0.4 V
    always_comb begin
        if (feedback_level >= ENTRY) begin
            fb_span = '0;
        end else if (feedback_level <= FLOOR) begin
            fb_span = ENTRY - FLOOR;
        end else begin
            fb_span = ENTRY - feedback_level;
        end
        dead_target = 16'((32'(fb_span) * 32'(DEAD_T)) / 32'(ENTRY - FLOOR));
    end

    // valley selection with hysteresis
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            valley_hold <= qrvl_pkg::VALLEY_MIN;
        end else begin
            if (valley_hold < qrvl_pkg::VALLEY_MAX &&
                feedback_level < FB_W'(qrvl_pkg::FALL_MV[valley_hold])) begin
                valley_hold <= valley_hold + 3'h1;
            end else if (valley_hold > qrvl_pkg::VALLEY_MIN &&
                         feedback_level >= FB_W'(qrvl_pkg::RISE_MV[valley_hold - 3'h1])) begin
                valley_hold <= valley_hold - 3'h1;
            end
        end
    end

    // foldback entry/exit with lockout
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rapid_foldback <= 1'b0;
            lock_cnt       <= '0;
        end else begin
            if (lock_cnt != 32'h0) begin
                lock_cnt <= lock_cnt - 32'h1;
            end
            if (rapid_foldback && (feedback_below_skip || feedback_level >= fifth_rise)) begin
                rapid_foldback <= 1'b0;
                lock_cnt       <= 32'(LOCKOUT_CYC);
            end else if (lock_cnt == 32'h0) begin
                if (!rapid_foldback && valley_hold == qrvl_pkg::VALLEY_MAX && feedback_level <= ENTRY) begin
                    rapid_foldback <= 1'b1;
                    lock_cnt       <= 32'(LOCKOUT_CYC);
                end else if (rapid_foldback && feedback_level > EXIT) begin
                    rapid_foldback <= 1'b0;
                    lock_cnt       <= 32'(LOCKOUT_CYC);
                end
            end
        end
    end

    // peak setpoint: boosted floor, linear reduction in foldback
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            foldback_mode <= 1'b0;
            peak_floor_mv <= '0;
            peak_limit_mv <= '0;
        end else begin
            foldback_mode <= rapid_foldback;
            peak_floor_mv <= rapid_foldback ? 12'(qrvl_pkg::PEAK_BOOST_MV) : 12'h000;
            peak_limit_mv <= rapid_foldback ? 12'(qrvl_pkg::PEAK_BOOST_MV) - 12'(fb_span) : 12'h000;
        end
    end

    // switching cycle
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state      <= qrvl_pkg::QRVL_WAIT;
            gate_pulse <= 1'b0;
            period_cnt <= '0;
            tout_cnt   <= '0;
            dead_cnt   <= '0;
            valley_cnt <= '0;
        end else begin
            period_cnt <= (period_cnt == 16'hFFFF) ? period_cnt : period_cnt + 16'h1;
            unique case (state)
                qrvl_pkg::QRVL_ON: begin
                    if (cs_if.level) begin
                        gate_pulse <= 1'b0;
                        state      <= qrvl_pkg::QRVL_WAIT;
                    end
                end
                qrvl_pkg::QRVL_WAIT: begin
                    // demag start: ringing must begin before hunting
                    if (!demag_if.level) begin
                        state      <= qrvl_pkg::QRVL_HUNT;
                        tout_cnt   <= '0;
                        valley_cnt <= '0;
                    end
                end
                qrvl_pkg::QRVL_HUNT: begin
                    tout_cnt <= demag_if.fall ? 16'h0000 : tout_cnt + 16'h1;
                    if (tout_evt) begin
                        tout_cnt <= '0;
                    end
                    if (period_cnt >= FMIN_T && valley_cnt != 3'h0) begin
                        gate_pulse <= 1'b1;
                        period_cnt <= '0;
                        state      <= qrvl_pkg::QRVL_ON;
                    end else if (valley_evt) begin
                        if (valley_cnt + 3'h1 >= valley_hold && clamp_ok) begin
                            if (rapid_foldback && dead_target != 16'h0000) begin
                                dead_cnt <= '0;
                                state    <= qrvl_pkg::QRVL_DEAD;
                            end else begin
                                gate_pulse <= 1'b1;
                                period_cnt <= '0;
                                state      <= qrvl_pkg::QRVL_ON;
                            end
                        end else if (valley_cnt != qrvl_pkg::VALLEY_MAX) begin
                            valley_cnt <= valley_cnt + 3'h1;
                        end
                    end
                end
                qrvl_pkg::QRVL_DEAD: begin
                    dead_cnt <= dead_cnt + 16'h1;
                    if (dead_cnt >= dead_target || period_cnt >= FMIN_T) begin
                        gate_pulse <= 1'b1;
                        period_cnt <= '0;
                        state      <= qrvl_pkg::QRVL_ON;
                    end
                end
            endcase
        end
    end

    // jitter triangle and per-cycle polarity
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            jit_div         <= '0;
            jit_up          <= 1'b1;
            jitter_mv       <= '0;
            jitter_negative <= 1'b0;
        end else begin
            if (jit_div == 16'(qrvl_pkg::JIT_STEP_CYC - 1)) begin
                jit_div <= '0;
                if (jit_up) begin
                    jitter_mv <= jitter_mv + 6'h01;
                    jit_up    <= (jitter_mv != 6'(qrvl_pkg::JIT_AMP_MV - 1));
                end else begin
                    jitter_mv <= jitter_mv - 6'h01;
                    jit_up    <= (jitter_mv == 6'h01);
                end
            end else begin
                jit_div <= jit_div + 16'h1;
            end
            if (state == qrvl_pkg::QRVL_ON && cs_if.level) begin
                jitter_negative <= ~jitter_negative;
            end
        end
    end
endmodule : qrvl_switch_ctrl
`default_nettype wire

// file: qrvl_pkg.sv
package qrvl_pkg;
    localparam int CLK_HZ              = 20_000_000;
    localparam int CLK_NS              = 50;
    // jitter triangle, 50 mV full scale in 1 mV codes, 250 Hz
    localparam int JIT_AMP_MV          = 50;
    localparam int JIT_RATE_HZ         = 250;
    localparam int JIT_STEP_CYC        = CLK_HZ / (JIT_RATE_HZ * 2 * JIT_AMP_MV);
    localparam int DEMAG_TRIG_MV       = 55;
    // valley timeouts
    localparam int STEADY_TOUT_NS      = 6000;
    localparam int STARTUP_TOUT_US     = 100;
    localparam int STEADY_TOUT_CYC     = STEADY_TOUT_NS / CLK_NS;
    localparam int STARTUP_TOUT_CYC    = STARTUP_TOUT_US * 1000 / CLK_NS;
    // frequency clamps
    localparam int FREQ_LIMIT_PIN_HZ             = 140_000;
    localparam int FREQ_LIMIT_PIN_CYC            = (CLK_HZ + FREQ_LIMIT_PIN_HZ - 1) / FREQ_LIMIT_PIN_HZ;
    localparam int FMIN_HZ             = 25_000;
    localparam int FMIN_CYC            = CLK_HZ / FMIN_HZ;
    localparam int FREQ_LIMIT_OFF_MV   = 3000;
    // foldback
    localparam int FB_ENTRY_MV         = 800;
    localparam int FB_EXIT_MV          = 750;
    localparam int FB_FLOOR_MV         = 400;
    localparam int PEAK_BOOST_MV       = 400;
    localparam int MAX_DEAD_NS         = 36000;
    localparam int MAX_DEAD_CYC        = MAX_DEAD_NS / CLK_NS;
    localparam int LOCKOUT_MS          = 1;
    localparam int LOCKOUT_CYC         = LOCKOUT_MS * 1_000_000 / CLK_NS;
    localparam int VALLEY_HYST_MV      = 600;
    localparam int NUM_VALLEYS         = 6;
    localparam int FB_W                = 12;
    localparam int CNT_W               = 16;
    localparam int MV_W                = 12;
    localparam logic [2:0] VALLEY_MIN  = 3'h1;
    localparam logic [2:0] VALLEY_MAX  = 3'h6;
    localparam int FALL_MV [1:5] = '{1400, 1200, 1100, 1000, 900};
    localparam int RISE_MV [1:5] = '{2000, 1800, 1700, 1600, 1500};

    typedef enum logic [1:0] {
        QRVL_ON   = 2'b00,
        QRVL_WAIT = 2'b01,
        QRVL_HUNT = 2'b11,
        QRVL_DEAD = 2'b10
    } qrvl_state_t;
endpackage : qrvl_pkg

// file: qrvl_sync_if.sv
`timescale 1ns/100ps
`default_nettype none
interface qrvl_sync_if;
    logic raw;
    logic level;
    logic fall;
    modport src (output raw);
    modport dst (output level, output fall, input raw);
endinterface : qrvl_sync_if
`default_nettype wire

// file: qrvl_sync.sv
`timescale 1ns/100ps
`default_nettype none
module qrvl_sync (
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    qrvl_sync_if.dst  s
);
    logic s1;
    logic s2;
    logic s3;
    logic level_q;

    // three stages; the level moves only when stages two and three agree
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end else begin
            s1 <= s.raw;
            s2 <= s1;
            s3 <= s2;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            level_q <= 1'b0;
        end else if (s2 == s3) begin
            level_q <= s3;
        end
    end

    assign s.level = level_q;
    assign s.fall  = level_q & (s2 == s3) & ~s3;
endmodule : qrvl_sync
`default_nettype wire

// file: qrvl_plant.sv
`timescale 1ns/100ps
`default_nettype none
module qrvl_plant (
    input  wire logic       ref_clk,
    input  wire logic       gate_pulse,
    input  wire logic [3:0] n_valleys,
    input  wire logic [7:0] on_cyc,
    output logic            demag_below_thresh,
    output logic            cs_trip
);
    int t  = 0;
    int ph = 1000;

    initial begin
        demag_below_thresh = 1'b0;
        cs_trip            = 1'b0;
    end

    // ringing damps out after n_valleys falls, so later valleys come only from timeouts
    always @(negedge ref_clk) begin
        if (gate_pulse) begin
            ph                 <= 0;
            t                  <= t + 1;
            cs_trip            <= (t >= int'(on_cyc));
            demag_below_thresh <= 1'b0;
        end else begin
            t       <= 0;
            ph      <= ph + 1;
            cs_trip <= 1'b0;
            if (ph < 40)
                demag_below_thresh <= 1'b1;
            else if (ph < 40 + 20 * int'(n_valleys))
                demag_below_thresh <= ((ph - 40) % 20) < 10;
            else
                demag_below_thresh <= 1'b0;
        end
    end
endmodule : qrvl_plant
`default_nettype wire

// file: qrvl_switch_ctrl_sva.sv
`timescale 1ns/100ps
`default_nettype none
module qrvl_switch_ctrl_sva #(
    parameter int FB_W        = qrvl_pkg::FB_W,
    parameter int LOCKOUT_CYC = qrvl_pkg::LOCKOUT_CYC,
    parameter int CLAMP_CYC   = qrvl_pkg::FREQ_LIMIT_PIN_CYC
) (
    input wire logic            ref_clk,
    input wire logic            sys_rst,
    input wire logic            demag_below_thresh,
    input wire logic            cs_trip,
    input wire logic [FB_W-1:0] feedback_level,
    input wire logic            feedback_below_skip,
    input wire logic            soft_start,
    input wire logic            freq_limit_enable,
    input wire logic            freq_limit_pin_high,
    input wire logic [15:0]     freq_limit_cyc,
    input wire logic            gate_pulse,
    input wire logic            jitter_negative,
    input wire logic [5:0]      jitter_mv,
    input wire logic [2:0]      valley_hold,
    input wire logic            foldback_mode,
    input wire logic            rapid_foldback,
    input wire logic [11:0]     peak_floor_mv,
    input wire logic [11:0]     peak_limit_mv
);
    logic        gate_q;
    logic        rff_q;
    logic        seen;
    logic        last_neg;
    logic        have_pol;
    logic [15:0] since_rise;
    logic [15:0] since_rff;
    wire         rise     = gate_pulse & ~gate_q;
    wire         clamp_on = freq_limit_enable & ~freq_limit_pin_high;

    // period tracking restarts after soft-start, where long timeouts are legal
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            gate_q     <= 1'b0;
            seen       <= 1'b0;
            have_pol   <= 1'b0;
            last_neg   <= 1'b0;
            since_rise <= 16'h0000;
        end else begin
            gate_q     <= gate_pulse;
            seen       <= ~soft_start & (seen | rise);
            since_rise <= rise ? 16'h0001 : since_rise + 16'h0001;
            if (gate_q & ~gate_pulse) begin
                last_neg <= jitter_negative;
                have_pol <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rff_q     <= 1'b0;
            since_rff <= 16'hFFFF;
        end else begin
            rff_q <= rapid_foldback;
            if (rapid_foldback != rff_q)
                since_rff <= 16'h0000;
            else if (since_rff != 16'hFFFF)
                since_rff <= since_rff + 16'h0001;
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    chk_valley_range: assert property (valley_hold inside {[3'h1:3'h6]})
        else $error("valley selection out of range");
    chk_jitter_range: assert property (jitter_mv <= 6'h32)
        else $error("jitter amplitude above full scale");
    chk_jitter_flip: assert property (gate_q && !gate_pulse && have_pol |-> jitter_negative != last_neg)
        else $error("jitter polarity repeated");
    chk_valley_step: assert property ($changed(valley_hold) |->
        valley_hold == $past(valley_hold) + 3'h1 || valley_hold == $past(valley_hold) - 3'h1)
        else $error("valley selection skipped a step");
    chk_gate_end: assert property ($rose(cs_trip) && gate_pulse |-> ##[1:6] !gate_pulse)
        else $error("on-time not ended by current trip");
    chk_min_freq: assert property (seen |-> since_rise <= qrvl_pkg::FMIN_CYC + 8)
        else $error("switching period above minimum frequency limit");
    chk_max_freq: assert property (rise && seen && clamp_on |->
        since_rise >= ((freq_limit_cyc == 16'h0000) ? 16'(CLAMP_CYC) : freq_limit_cyc))
        else $error("switching period below clamp");
    chk_rff_entry: assert property ($rose(rapid_foldback) |-> valley_hold == 3'h6)
        else $error("foldback entered off the sixth valley");
    chk_rff_lockout: assert property (rapid_foldback != rff_q && since_rff < LOCKOUT_CYC - 1 |-> !rapid_foldback)
        else $error("foldback entered inside lockout");

    cov_rff_in: cover property ($rose(rapid_foldback));
    cov_rff_out: cover property ($fell(rapid_foldback));
    cov_fifth: cover property (rise && valley_hold == 3'h5);
endmodule : qrvl_switch_ctrl_sva

bind qrvl_switch_ctrl qrvl_switch_ctrl_sva #(
    .FB_W        (FB_W),
    .LOCKOUT_CYC (LOCKOUT_CYC),
    .CLAMP_CYC   (CLAMP_CYC)
) u_sva (.*);
`default_nettype wire

// file: qrvl_switch_ctrl_tb.sv
`timescale 1ns/100ps
`default_nettype none
module qrvl_switch_ctrl_tb;
    logic        ref_clk             = 1'b0;
    logic        sys_rst             = 1'b1;
    logic        demag_below_thresh;
    logic        cs_trip;
    logic [11:0] feedback_level      = 12'h834;
    logic        feedback_below_skip = 1'b0;
    logic        soft_start          = 1'b0;
    logic        freq_limit_enable   = 1'b0;
    logic        freq_limit_pin_high = 1'b0;
    logic [15:0] freq_limit_cyc      = 16'h0000;
    logic        gate_pulse;
    logic        jitter_negative;
    logic [5:0]  jitter_mv;
    logic [2:0]  valley_hold;
    logic        foldback_mode;
    logic        rapid_foldback;
    logic [11:0] peak_floor_mv;
    logic [11:0] peak_limit_mv;
    logic [3:0]  n_valleys           = 4'h6;
    logic [7:0]  on_cyc              = 8'h08;
    int          err_count           = 0;
    int          cmp_count           = 0;
    int          cyc                 = 0;
    time         last_fall           = 0;

    always #25 ref_clk = ~ref_clk;

    // lockout shortened so the run stays brief
    qrvl_switch_ctrl #(.LOCKOUT_CYC(200)) DUT (.*);
    qrvl_plant u_plant (.*);

    always @(negedge demag_below_thresh) last_fall = $time;

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 80000) begin
            err_count++;
            end_of_test;
        end
    end

    task automatic end_of_test;
        if (err_count == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_of_test

    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_val

    task automatic chk_rng(input int got, input int lo, input int up);
        cmp_count++;
        if (got < lo || got > up) begin
            err_count++;
            $display("Error %0t: %0d outside %0d..%0d", $time, got, lo, up);
        end
    endtask : chk_rng

    task automatic step(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : step

    task automatic do_reset;
        sys_rst = 1'b1;
        step(3);
        sys_rst = 1'b0;
    endtask : do_reset

    // cycles since previous rise and since last valley fall
    task automatic period(output int p, output int g);
        time t0;
        @(posedge gate_pulse);
        t0 = $time;
        @(posedge gate_pulse);
        p = int'(($time - t0) / 50);
        g = int'(($time - last_fall) / 50);
        step(1);
    endtask : period

    task automatic t_select;
        int fbv [12] = '{1300, 1150, 1050, 950, 850, 1450, 1550, 1650, 1750, 1850, 1950, 2050};
        int exv [12] = '{2, 3, 4, 5, 6, 6, 5, 4, 3, 2, 2, 1};
        step(1000);
        chk_val(valley_hold, 3'h1);
        foreach (fbv[i]) begin
            feedback_level = 12'(fbv[i]);
            step(1500);
            chk_val(valley_hold, 16'(exv[i]));
        end
    endtask : t_select

    task automatic t_timeout;
        int p;
        int g;
        feedback_level = 12'(950);
        step(5000);
        chk_val(valley_hold, 3'h5);
        for (int nv = 5; nv >= 3; nv--) begin
            n_valleys = 4'(nv);
            period(p, g);
            period(p, g);
            chk_rng(g, (5 - nv) * 120, (5 - nv) * 120 + 8);
        end
        soft_start = 1'b1;
        // long timeout never fires, so the minimum-frequency restart ends the period
        period(p, g);
        period(p, g);
        chk_rng(p, 800, 804);
        soft_start = 1'b0;
    endtask : t_timeout

    task automatic t_foldback;
        feedback_level = 12'(850);
        step(4000);
        chk_val(valley_hold, 3'h6);
        chk_val(rapid_foldback, 1'b0);
        feedback_level = 12'(700);
        @(posedge rapid_foldback);
        step(2);
        chk_val(foldback_mode, 1'b1);
        chk_val(peak_floor_mv, 12'h190);
        chk_val(peak_limit_mv, 12'h12C);
        feedback_level = 12'(900);
        step(150);
        chk_val(rapid_foldback, 1'b1);
        step(100);
        chk_val(rapid_foldback, 1'b0);
        feedback_level = 12'(400);
        @(posedge rapid_foldback);
        step(1);
        feedback_below_skip = 1'b1;
        step(10);
        chk_val(rapid_foldback, 1'b0);
        feedback_below_skip = 1'b0;
        @(posedge rapid_foldback);
        step(2000);
        chk_val(rapid_foldback, 1'b1);
        feedback_level = 12'(1520);
        step(10);
        chk_val(rapid_foldback, 1'b0);
    endtask : t_foldback

    task automatic clamp_case(input logic en, input logic hi, input logic [15:0] lim, input int lo, input int up);
        int p;
        int g;
        freq_limit_enable   = en;
        freq_limit_pin_high = hi;
        freq_limit_cyc      = lim;
        do_reset;
        period(p, g);
        period(p, g);
        chk_rng(p, lo, up);
    endtask : clamp_case

    task automatic t_clamp;
        feedback_level = 12'(2100);
        n_valleys      = 4'h6;
        clamp_case(1'b0, 1'b0, 16'h0000, 20, 142);
        clamp_case(1'b1, 1'b0, 16'h0000, 143, 800);
        clamp_case(1'b1, 1'b1, 16'h0000, 20, 142);
        clamp_case(1'b1, 1'b0, 16'h00C8, 200, 800);
    endtask : t_clamp

    initial begin
        do_reset;
        t_select;
        t_timeout;
        t_foldback;
        t_clamp;
        end_of_test;
    end
endmodule : qrvl_switch_ctrl_tb
`default_nettype wire
